/* core/jtag_tap_defines.svh */
// Purpose: constants of the test access port and its shift chains
// Assumes: a four-bit instruction chain and 35-bit debug access chains
// Notes: boundary chain keeps input, output, enable per pad, input first
`ifndef JTAG_TAP_DEFINES_SVH
`define JTAG_TAP_DEFINES_SVH

// Instruction codes
`define IR_W 4
`define IR_EXTEST 4'h0
`define IR_INTEST 4'h1
`define IR_SAMPLE 4'h2
`define IR_ABORT 4'h8
`define IR_DEBUG_PORT_ACCESS_CHAIN 4'hA
`define IR_ACCESS_PORT_ACCESS_CHAIN 4'hB
`define IR_IDCODE 4'hE
`define IR_BYPASS 4'hF

// Chain widths and field positions
`define DAP_W 35
`define ACK_W 3
`define NPAD 8
`define BSR_W 24
`define BSR_IN 0
`define BSR_OUT 1
`define BSR_OE 2

// Acknowledge codes
`define ACK_OK 3'h2
`define ACK_WAIT 3'h1

// Identification value, arbitrary, low bit must stay 1
`define IDCODE_VAL 32'h0000_1001

// Word sent toward the debug access logic: kind then chain content
`define DBGW 37
`define KIND_ABORT 2'h0
`define KIND_DP 2'h1
`define KIND_AP 2'h2

// Shared pin configuration, five pins, and switch and reset counts
`define PIN_N 5
`define PIN_CFG_RST 5'h1F
`define SWD_PASSES 2'h2
`define TLR_TMS_CNT 3'h5
`endif

/* core/jtag_tap_pkg.sv */
// Purpose: types of the test access port
// Assumes: nothing beyond the defines header
// Notes: states follow the usual sixteen-state controller
package jtag_tap_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_state_t;

  typedef enum logic [2:0] {
    SEL_BSR, SEL_ABORT, SEL_DP, SEL_AP, SEL_ID, SEL_BYP
  } chain_sel_t;
endpackage

/* core/jtag_tap_port.sv */
// Purpose: test access port with its instruction and data chains
// Assumes: clk_i is much faster than the test clock, which it samples
// Notes: apart from the shared pin configuration, no register here is reachable from the peripheral bus
`include "jtag_tap_defines.svh"

// Behaviour
// - Capture states load the chosen chain; shift states move it out on TDO.
// - Fresh bits enter from TDI while shifting; update states load holders.
// - After reset the five shared pins are test pins; selects read 1.
// - Writing 0s to the alternate selects turns the pins into plain I/O.
// - Capture of a debug access chain returns last result and 3-bit ack.
// - Two instruction passes without shift enable wire debug, disable test port.
// - A four-bit instruction chain feeds a holder that is the instruction.
// - Code 0000 drives preloaded boundary values onto the pads.
// - Code 0001 drives preloaded boundary values into the core.
// - Code 0010 captures pad input, output, enable and shifts in preload.
// - 1000 selects abort chain input only; 1010 and 1011 the access chains.
// - Code 1110 loads identification bits and shifts them out.
// - Code 1111 links TDI to TDO through one stage.
// - Every unassigned code decodes as the one-stage bypass.
// - Under 0000 pads take output and enable from preloaded bits.
// - Under 0000 the boundary chain still captures, shifts and loads.
// - Chains and instruction are reached only serially, never by bus.
// - Five rising test clocks with TMS high reach reset from any state except the pause states, which need six; instruction becomes 1110.
// - Test reset held low keeps the controller in its reset state.
// - TDO changes on falling test clock; inputs sampled on rising.
module jtag_tap_port (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trstn_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  input wire logic pin_cfg_we_i,
  input wire logic [`PIN_N-1:0] pin_alt_function_select_i,
  input wire logic [`PIN_N-1:0] pin_pullup_enable_i,
  output logic [`PIN_N-1:0] pin_alt_function_select_o,
  output logic [`PIN_N-1:0] pin_pullup_enable_o,
  output logic swd_enable_o,
  output logic jtag_enable_o,
  input wire logic [`NPAD-1:0] pad_in_i,
  input wire logic [`NPAD-1:0] core_out_i,
  input wire logic [`NPAD-1:0] core_oe_i,
  output logic [`NPAD-1:0] pad_out_o,
  output logic [`NPAD-1:0] pad_oe_o,
  output logic [`NPAD-1:0] core_in_o,
  output logic dbg_req_valid_o,
  output logic [`DBGW-1:0] dbg_req_data_o,
  input wire logic dbg_req_ready_i,
  input wire logic dbg_rsp_valid_i,
  input wire logic [31:0] dbg_rsp_data_i,
  input wire logic [`ACK_W-1:0] dbg_rsp_ack_i
);
  // Synchronisers and edge detect
  logic tck_s1, tck_s2, tck_d;
  logic tms_s1, tms_s2, tdi_s1, tdi_s2, trst_s1, trst_s2;
  logic [`NPAD-1:0] pad_s1, pad_s2;
  logic rise, fall, jtag_on;
  // Controller, chains and holders
  jtag_tap_pkg::tap_state_t tap_r, tap_nxt;
  jtag_tap_pkg::chain_sel_t sel;
  logic [`IR_W-1:0] ir_r, ir_sh_r;
  logic [`DAP_W-1:0] dr_sh_r, cap_val;
  logic [`BSR_W-1:0] bsr_hold_r;
  logic [`PIN_N-1:0] afsel_r, pur_r;
  logic [`NPAD-1:0] pad_out_r, pad_oe_r, core_in_r;
  logic [31:0] rsp_data_r;
  logic [`ACK_W-1:0] rsp_ack_r, ack_now;
  logic wait_r, swd_r, jtag_en_r, tdo_r, tdo_oe_r;
  logic [1:0] pass_cnt_r;
  logic [2:0] tms_cnt_r;
  logic upd_ir_fall, upd_dr_fall, cap_dr_rise;
  word_link_if lnk ();

  // Pick one field of every pad from a boundary image
  function automatic logic [`NPAD-1:0] bsr_field(
    input logic [`BSR_W-1:0] img, input int pos);
    logic [`NPAD-1:0] f;
    f = '0;
    for (int k = 0; k < `NPAD; k++) begin
      f[k] = img[3*k+pos];
    end
    return f;
  endfunction

  // Instruction decode; gaps fall back to the bypass stage
  function automatic jtag_tap_pkg::chain_sel_t decode(
    input logic [`IR_W-1:0] ir);
    unique case (ir)
      `IR_EXTEST, `IR_INTEST, `IR_SAMPLE: return jtag_tap_pkg::SEL_BSR;
      `IR_ABORT: return jtag_tap_pkg::SEL_ABORT;
      `IR_DEBUG_PORT_ACCESS_CHAIN: return jtag_tap_pkg::SEL_DP;
      `IR_ACCESS_PORT_ACCESS_CHAIN: return jtag_tap_pkg::SEL_AP;
      `IR_IDCODE: return jtag_tap_pkg::SEL_ID;
      default: return jtag_tap_pkg::SEL_BYP;
    endcase
  endfunction

  // Shift one step toward TDO, new bit entering at the chain's far end
  function automatic logic [`DAP_W-1:0] shift_in(
    input logic [`DAP_W-1:0] cur, input logic bit_in,
    input jtag_tap_pkg::chain_sel_t s);
    logic [`DAP_W-1:0] t;
    t = cur >> 1;
    unique case (s)
      jtag_tap_pkg::SEL_BSR: t[`BSR_W-1] = bit_in;
      jtag_tap_pkg::SEL_ID: t[31] = bit_in;
      jtag_tap_pkg::SEL_BYP: t[0] = bit_in;
      default: t[`DAP_W-1] = bit_in;
    endcase
    return t;
  endfunction

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tck_s1 <= 1'b0;
      tck_s2 <= 1'b0;
      tck_d <= 1'b0;
      tms_s1 <= 1'b1;
      tms_s2 <= 1'b1;
      tdi_s1 <= 1'b1;
      tdi_s2 <= 1'b1;
      trst_s1 <= 1'b0;
      trst_s2 <= 1'b0;
      pad_s1 <= '0;
      pad_s2 <= '0;
    end else begin
      tck_s1 <= tck_i;
      tck_s2 <= tck_s1;
      tck_d <= tck_s2;
      tms_s1 <= tms_i;
      tms_s2 <= tms_s1;
      tdi_s1 <= tdi_i;
      tdi_s2 <= tdi_s1;
      trst_s1 <= trstn_i;
      trst_s2 <= trst_s1;
      pad_s1 <= pad_in_i;
      pad_s2 <= pad_s1;
    end
  end

  // The port listens only while every shared pin is in test function
  assign jtag_on = (&afsel_r) & ~swd_r;
  assign rise = tck_s2 & ~tck_d & jtag_on;
  assign fall = ~tck_s2 & tck_d & jtag_on;
  assign sel = decode(ir_r);
  assign upd_ir_fall = fall && tap_r == jtag_tap_pkg::UPD_IR;
  assign upd_dr_fall = fall && tap_r == jtag_tap_pkg::UPD_DR;
  assign cap_dr_rise = rise && tap_r == jtag_tap_pkg::CAP_DR;
  // A full buffer shows as wait so the probe retries; an abort word scanned while it is full is lost
  assign ack_now = lnk.in_ready ? rsp_ack_r : `ACK_WAIT;

  // Controller next state from sampled TMS
  always_comb begin
    tap_nxt = tap_r;
    unique case (tap_r)
      jtag_tap_pkg::TLR:
        tap_nxt = tms_s2 ? jtag_tap_pkg::TLR : jtag_tap_pkg::RTI;
      jtag_tap_pkg::RTI, jtag_tap_pkg::UPD_DR, jtag_tap_pkg::UPD_IR:
        tap_nxt = tms_s2 ? jtag_tap_pkg::SEL_DR : jtag_tap_pkg::RTI;
      jtag_tap_pkg::SEL_DR:
        tap_nxt = tms_s2 ? jtag_tap_pkg::SEL_IR : jtag_tap_pkg::CAP_DR;
      jtag_tap_pkg::CAP_DR, jtag_tap_pkg::SH_DR, jtag_tap_pkg::EX2_DR:
        tap_nxt = tms_s2 ? jtag_tap_pkg::EX1_DR : jtag_tap_pkg::SH_DR;
      jtag_tap_pkg::EX1_DR:
        tap_nxt = tms_s2 ? jtag_tap_pkg::UPD_DR : jtag_tap_pkg::PA_DR;
      jtag_tap_pkg::PA_DR:
        tap_nxt = tms_s2 ? jtag_tap_pkg::EX2_DR : jtag_tap_pkg::PA_DR;
      jtag_tap_pkg::SEL_IR:
        tap_nxt = tms_s2 ? jtag_tap_pkg::TLR : jtag_tap_pkg::CAP_IR;
      jtag_tap_pkg::CAP_IR, jtag_tap_pkg::SH_IR, jtag_tap_pkg::EX2_IR:
        tap_nxt = tms_s2 ? jtag_tap_pkg::EX1_IR : jtag_tap_pkg::SH_IR;
      jtag_tap_pkg::EX1_IR:
        tap_nxt = tms_s2 ? jtag_tap_pkg::UPD_IR : jtag_tap_pkg::PA_IR;
      jtag_tap_pkg::PA_IR:
        tap_nxt = tms_s2 ? jtag_tap_pkg::EX2_IR : jtag_tap_pkg::PA_IR;
    endcase
  end

  // Controller state; test reset overrides any clock activity
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tap_r <= jtag_tap_pkg::TLR;
    end else if (!trst_s2) begin
      tap_r <= jtag_tap_pkg::TLR;
    end else if (rise) begin
      tap_r <= tap_nxt;
    end
  end

  // Instruction chain and its holder
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ir_r <= `IR_IDCODE;
      ir_sh_r <= `IR_IDCODE;
    end else if (tap_r == jtag_tap_pkg::TLR) begin
      ir_r <= `IR_IDCODE;
    end else if (rise && tap_r == jtag_tap_pkg::CAP_IR) begin
      ir_sh_r <= ir_r;
    end else if (rise && tap_r == jtag_tap_pkg::SH_IR) begin
      ir_sh_r <= {tdi_s2, ir_sh_r[`IR_W-1:1]};
    end else if (upd_ir_fall) begin
      ir_r <= ir_sh_r;
    end
  end

  // Capture image of the selected data chain
  always_comb begin
    cap_val = '0;
    unique case (sel)
      jtag_tap_pkg::SEL_BSR: begin
        for (int k = 0; k < `NPAD; k++) begin
          cap_val[3*k+`BSR_IN] = pad_s2[k];
          cap_val[3*k+`BSR_OUT] = pad_out_r[k];
          cap_val[3*k+`BSR_OE] = pad_oe_r[k];
        end
      end
      jtag_tap_pkg::SEL_DP, jtag_tap_pkg::SEL_AP:
        cap_val = {rsp_data_r, ack_now};
      jtag_tap_pkg::SEL_ID: cap_val[31:0] = `IDCODE_VAL;
      default: cap_val = '0; // Abort chain is write only
    endcase
  end

  // Data chain: capture, shift, and update of the boundary holder
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dr_sh_r <= '0;
      bsr_hold_r <= '0;
      wait_r <= 1'b0;
    end else if (cap_dr_rise) begin
      dr_sh_r <= cap_val;
      wait_r <= ~lnk.in_ready;
    end else if (rise && tap_r == jtag_tap_pkg::SH_DR) begin
      dr_sh_r <= shift_in(dr_sh_r, tdi_s2, sel);
    end else if (upd_dr_fall && sel == jtag_tap_pkg::SEL_BSR) begin
      bsr_hold_r <= dr_sh_r[`BSR_W-1:0];
    end
  end

  // Debug words leave on update; slot was seen free at capture
  assign lnk.in_valid = upd_dr_fall && !wait_r
    && (sel == jtag_tap_pkg::SEL_ABORT || sel == jtag_tap_pkg::SEL_DP
    || sel == jtag_tap_pkg::SEL_AP);
  assign lnk.in_data = {(sel == jtag_tap_pkg::SEL_ABORT) ? `KIND_ABORT :
    (sel == jtag_tap_pkg::SEL_DP) ? `KIND_DP : `KIND_AP, dr_sh_r};
  assign lnk.out_ready = dbg_req_ready_i;
  assign dbg_req_valid_o = lnk.out_valid;
  assign dbg_req_data_o = lnk.out_data;

  word_buffer u_buf (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .lnk(lnk)
  );

  // Latest answer of the debug access logic
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rsp_data_r <= '0;
      rsp_ack_r <= `ACK_OK;
    end else if (dbg_rsp_valid_i) begin
      rsp_data_r <= dbg_rsp_data_i;
      rsp_ack_r <= dbg_rsp_ack_i;
    end
  end

  // Pads and core inputs follow the boundary holder under test codes
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pad_out_r <= '0;
      pad_oe_r <= '0;
      core_in_r <= '0;
    end else begin
      if (ir_r == `IR_EXTEST) begin
        pad_out_r <= bsr_field(bsr_hold_r, `BSR_OUT);
        pad_oe_r <= bsr_field(bsr_hold_r, `BSR_OE);
      end else begin
        pad_out_r <= core_out_i;
        pad_oe_r <= core_oe_i;
      end
      if (ir_r == `IR_INTEST) begin
        core_in_r <= bsr_field(bsr_hold_r, `BSR_IN);
      end else begin
        core_in_r <= pad_s2;
      end
    end
  end

  // Shared pin configuration; a system reset, or a write of 1s to the selects while wire debug is off, restores test use
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      afsel_r <= `PIN_CFG_RST;
      pur_r <= `PIN_CFG_RST;
    end else if (pin_cfg_we_i) begin
      afsel_r <= pin_alt_function_select_i;
      pur_r <= pin_pullup_enable_i;
    end
  end

  // Wire-debug switch: count instruction passes that never shift
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pass_cnt_r <= '0;
      swd_r <= 1'b0;
    end else if (rise && (tap_r == jtag_tap_pkg::SH_IR
        || tap_r == jtag_tap_pkg::CAP_DR)) begin
      pass_cnt_r <= '0;
    end else if (upd_ir_fall) begin
      if (pass_cnt_r + 2'h1 == `SWD_PASSES) begin
        swd_r <= 1'b1;
      end
      pass_cnt_r <= pass_cnt_r + 2'h1;
    end
  end

  // TDO moves only on falling test clock, idle outside shifting
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (!jtag_on) begin
      tdo_oe_r <= 1'b0;
    end else if (fall) begin
      if (tap_r == jtag_tap_pkg::SH_IR) begin
        tdo_r <= ir_sh_r[0];
        tdo_oe_r <= 1'b1;
      end else if (tap_r == jtag_tap_pkg::SH_DR) begin
        tdo_r <= dr_sh_r[0];
        tdo_oe_r <= 1'b1;
      end else begin
        tdo_oe_r <= 1'b0;
      end
    end
  end

  // Status flops and helper count of TMS-high rising edges
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      jtag_en_r <= 1'b1;
      tms_cnt_r <= '0;
    end else begin
      jtag_en_r <= jtag_on;
      if (rise) begin
        if (!tms_s2) begin
          tms_cnt_r <= '0;
        end else if (tms_cnt_r != `TLR_TMS_CNT) begin
          tms_cnt_r <= tms_cnt_r + 3'h1;
        end
      end
    end
  end

  // Port outputs, each from a flop; instruction state has no bus path
  assign tdo_o = tdo_r;
  assign tdo_oe_o = tdo_oe_r;
  assign pin_alt_function_select_o = afsel_r;
  assign pin_pullup_enable_o = pur_r;
  assign swd_enable_o = swd_r;
  assign jtag_enable_o = jtag_en_r;
  assign pad_out_o = pad_out_r;
  assign pad_oe_o = pad_oe_r;
  assign core_in_o = core_in_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence second_pass;
    (pass_cnt_r == 2'h1) && upd_ir_fall;
  endsequence

  chk_tms_five_reset: assert property (
    (tms_cnt_r == 3'h5) |-> tap_r == jtag_tap_pkg::TLR)
    else $error("five TMS-high edges did not reach reset");
  chk_trst_holds_tlr: assert property (
    !trst_s2 |=> tap_r == jtag_tap_pkg::TLR)
    else $error("test reset did not force reset state");
  chk_ir_default_id: assert property (
    tap_r == jtag_tap_pkg::TLR |=> ir_r == 4'hE)
    else $error("instruction not IDCODE in reset state");
  chk_tdo_on_fall: assert property (
    $changed(tdo_r) |-> $past(fall))
    else $error("TDO changed away from falling edge");
  chk_gap_bypass: assert property (
    !(ir_r inside {4'h0, 4'h1, 4'h2, 4'h8, 4'hA, 4'hB, 4'hE})
    |-> sel == jtag_tap_pkg::SEL_BYP)
    else $error("unassigned code did not select bypass");
  chk_extest_pads: assert property (
    ir_r == 4'h0 ##1 ir_r == 4'h0 |-> pad_out_r
    == bsr_field($past(bsr_hold_r), 1) && pad_oe_r
    == bsr_field($past(bsr_hold_r), 2))
    else $error("EXTEST pads not from boundary holder");
  chk_swd_switch: assert property (
    second_pass |=> swd_r ##1 !jtag_en_r)
    else $error("wire debug not enabled after two passes");
  chk_ack_capture: assert property (
    cap_dr_rise && sel == jtag_tap_pkg::SEL_DP
    |=> dr_sh_r[2:0] == $past(ack_now))
    else $error("access chain capture lost the acknowledge");
  chk_ir_update: assert property (
    upd_ir_fall && tap_r != jtag_tap_pkg::TLR |=> ir_r == $past(ir_sh_r))
    else $error("instruction holder missed its update");
  chk_pin_cfg: assert property (
    pin_cfg_we_i |=> afsel_r == $past(pin_alt_function_select_i))
    else $error("pin select write not applied");
endmodule

/* core/word_buffer.sv */
// Purpose: two-entry buffer for words toward the debug access logic
// Assumes: single clock, asynchronous active-low reset
// Notes: all outputs come from flip-flops; ready falls only when full
`include "jtag_tap_defines.svh"
module word_buffer (
  input wire logic clk_i,
  input wire logic resetn_i,
  word_link_if.store lnk
);
  logic head_v_r;
  logic spare_v_r;
  logic [`DBGW-1:0] head_r;
  logic [`DBGW-1:0] spare_r;
  logic push;
  logic pop;

  // Handshakes on each side
  assign push = lnk.in_valid & ~spare_v_r;
  assign pop = head_v_r & lnk.out_ready;
  assign lnk.in_ready = ~spare_v_r;
  assign lnk.out_valid = head_v_r;
  assign lnk.out_data = head_r;

  // Head holds the oldest word, spare the one behind it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      head_v_r <= 1'b0;
      spare_v_r <= 1'b0;
      head_r <= '0;
      spare_r <= '0;
    end else if (push && pop) begin
      if (spare_v_r) begin
        head_r <= spare_r;
        spare_r <= lnk.in_data;
      end else begin
        head_r <= lnk.in_data;
      end
    end else if (push) begin
      if (head_v_r) begin
        spare_r <= lnk.in_data;
        spare_v_r <= 1'b1;
      end else begin
        head_r <= lnk.in_data;
        head_v_r <= 1'b1;
      end
    end else if (pop) begin
      head_r <= spare_r;
      head_v_r <= spare_v_r;
      spare_v_r <= 1'b0;
    end
  end

  // A held word must not move while the drain stalls
  chk_buffer_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    head_v_r && !lnk.out_ready |=> head_v_r && $stable(head_r))
    else $error("buffered word changed while stalled");
endmodule

/* core/word_link_if.sv */
// Purpose: carries debug words between the port and its buffer
// Assumes: both ends run on clk_i
// Notes: valid and ready on each side of the buffer
`include "jtag_tap_defines.svh"
interface word_link_if;
  logic in_valid;
  logic in_ready;
  logic [`DBGW-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [`DBGW-1:0] out_data;

  modport core (output in_valid, output in_data, output out_ready,
    input in_ready, input out_valid, input out_data);
  modport store (input in_valid, input in_data, input out_ready,
    output in_ready, output out_valid, output out_data);
endinterface

/* verification/jtag_probe.sv */
// Purpose: behavioural debug probe driving the test clock pins
// Assumes: test clock is 16 bench clocks, about 160 ns
// Notes: test clock rests low between scans; TMS and TDI move on its fall
module jtag_probe (
  input wire logic clk_i,
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels before the first scan
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // One test clock; TDO is taken just before the rise, long after it moved
  task automatic tick(input logic m, input logic d, output logic q);
    tms_o <= m;
    tdi_o <= d;
    repeat (8) @(posedge clk_i);
    q = tdo_i;
    tck_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    tck_o <= 1'b0;
  endtask

  // TMS walk, first bit lowest; TDI toggles so it never looks stuck
  task automatic walk(input logic [15:0] m, input int n);
    logic q;
    for (int i = 0; i < n; i++) tick(m[i], ~tdi_o, q);
  endtask

  // Scan from idle to idle through the data or instruction column
  task automatic scan(input logic ir, input int n, input logic [34:0] din,
    output logic [34:0] dout);
    logic q;
    dout = '0;
    walk(ir ? 16'h0003 : 16'h0001, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    walk(16'h0001, 2);
  endtask

  // Wire debug switch: reset, two instruction passes with no shift, reset
  task automatic preamble;
    walk(16'h001F, 5);
    walk(16'hEDB6, 16);
  endtask
endmodule

/* verification/testbench.sv */
// Purpose: self-checking bench for the test access port
// Assumes: bench clock 10 ns, test clock from the probe model
// Notes: the debug drain stalls on purpose to fill the word buffer
`include "jtag_tap_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic trstn = 1'b1, we = 1'b0, rdy = 1'b0, rsp_v = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, swd, jen, rq_v;
  logic [4:0] alt = 5'h1F, pu = 5'h1F, alt_o, pu_o;
  logic [7:0] pin = 8'hA5, cout = 8'h3C, coe = 8'h0F, pout, poe, cin;
  logic [36:0] rq_d;
  logic [31:0] rsp_d = 32'h0;
  logic [2:0] rsp_ack = 3'h0;
  logic [34:0] so;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;

  // Bench clock
  always #5 clk_i = ~clk_i;

  // Cycle ceiling; the run needs about 12000 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      tally_and_finish();
    end
  end

  jtag_probe i_probe (.clk_i(clk_i), .tdo_i(tdo), .tck_o(tck), .tms_o(tms),
    .tdi_o(tdi));
  jtag_tap_port i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .tck_i(tck),
    .tms_i(tms), .tdi_i(tdi), .trstn_i(trstn), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .pin_cfg_we_i(we), .pin_alt_function_select_i(alt),
    .pin_pullup_enable_i(pu), .pin_alt_function_select_o(alt_o),
    .pin_pullup_enable_o(pu_o), .swd_enable_o(swd), .jtag_enable_o(jen),
    .pad_in_i(pin), .core_out_i(cout), .core_oe_i(coe), .pad_out_o(pout),
    .pad_oe_o(poe), .core_in_o(cin), .dbg_req_valid_o(rq_v),
    .dbg_req_data_o(rq_d), .dbg_req_ready_i(rdy), .dbg_rsp_valid_i(rsp_v),
    .dbg_rsp_data_i(rsp_d), .dbg_rsp_ack_i(rsp_ack));

  task automatic chk(input string nm, input logic [63:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic ir(input logic [3:0] c);
    i_probe.scan(1'b1, 4, {31'h0, c}, so);
  endtask

  task automatic dr(input int n, input logic [34:0] d);
    i_probe.scan(1'b0, n, d, so);
  endtask

  // Field o of pad k sits at bit 3k+o of the boundary chain
  function automatic logic [7:0] pick(input logic [23:0] v, input int o);
    for (int k = 0; k < 8; k++) pick[k] = v[3*k+o];
  endfunction

  function automatic logic [23:0] pack3(input logic [7:0] a, b, c);
    for (int k = 0; k < 8; k++)
      pack3[3*k+:3] = {c[k], b[k], a[k]};
  endfunction

  // Pop the buffer head after checking it; ready is up for one cycle
  task automatic pop(input logic [36:0] w);
    @(negedge clk_i);
    chk("req_head", {rq_v, rq_d}, {1'b1, w});
    @(posedge clk_i) rdy <= 1'b1;
    @(posedge clk_i) rdy <= 1'b0;
  endtask

  task automatic t_reset;
    chk("rst", {alt_o, pu_o, swd, jen, tdo_oe}, 13'h1FFA);
  endtask

  task automatic t_ident;
    i_probe.walk(16'h0000, 1);
    dr(32, 35'h0);
    chk("idcode", so[31:0], `IDCODE_VAL);
    ir(4'h2);
    chk("ir_cap", so[3:0], 4'hE);
  endtask

  task automatic t_bypass;
    logic [3:0] c [9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hC, 4'hD,
      4'hF};
    foreach (c[i]) begin
      ir(c[i]);
      dr(4, 35'hB);
      chk("bypass", so[3:0], 4'h6);
    end
  endtask

  // Preload, drive out, reload under drive, drive in, release
  task automatic t_boundary;
    logic [23:0] p = 24'h5AC396;
    logic [23:0] q = 24'hA53C69;
    ir(4'h2);
    dr(24, {11'h0, p});
    chk("sample", so[23:0], pack3(pin, cout, coe));
    ir(4'h0);
    chk("ext", {poe, pout}, {pick(p, 2), pick(p, 1)});
    dr(24, {11'h0, q});
    chk("ext_cap", so[23:0], pack3(pin, pick(p, 1), pick(p, 2)));
    chk("ext_new", {poe, pout}, {pick(q, 2), pick(q, 1)});
    ir(4'h1);
    chk("intest", cin, pick(q, 0));
    ir(4'hF);
    chk("release", {poe, pout}, {coe, cout});
  endtask

  // Three requests against a stalled drain: the third is refused
  task automatic t_debug;
    logic [34:0] w [3] = '{35'h1_2345_678A, 35'h2_468A_CE0B, 35'h3_0F0F_0F0C};
    ir(4'hA);
    foreach (w[i]) dr(35, w[i]);
    chk("full_ack", so[2:0], `ACK_WAIT);
    pop({`KIND_DP, w[0]});
    pop({`KIND_DP, w[1]});
    @(negedge clk_i);
    chk("dropped", rq_v, 1'b0);
    @(posedge clk_i);
    rsp_v <= 1'b1;
    rsp_d <= 32'hC0DE_1234;
    rsp_ack <= `ACK_OK;
    @(posedge clk_i);
    rsp_v <= 1'b0;
    ir(4'hB);
    dr(35, w[2]);
    chk("result", so, {32'hC0DE_1234, `ACK_OK});
    pop({`KIND_AP, w[2]});
    ir(4'h8);
    dr(35, w[0]);
    chk("abort_cap", so, 35'h0);
    pop({`KIND_ABORT, w[0]});
  endtask

  task automatic t_tap_reset;
    ir(4'hF);
    i_probe.walk(16'h001F, 6);
    i_probe.walk(16'h0000, 1);
    dr(32, 35'h0);
    chk("tms_rst", so[31:0], `IDCODE_VAL);
    ir(4'hF);
    trstn <= 1'b0;
    repeat (6) @(posedge clk_i);
    trstn <= 1'b1;
    repeat (6) @(posedge clk_i);
    i_probe.walk(16'h0000, 1);
    dr(32, 35'h0);
    chk("trst", so[31:0], `IDCODE_VAL);
  endtask

  // Port off: a walk toward shift must be ignored
  task automatic t_pins;
    we <= 1'b1;
    alt <= 5'h00;
    @(posedge clk_i) we <= 1'b0;
    // Enable status trails the select by one flop
    repeat (2) @(negedge clk_i);
    chk("gpio", {alt_o, jen}, 6'h00);
    i_probe.walk(16'h0001, 3);
    repeat (8) @(posedge clk_i);
    chk("quiet", tdo_oe, 1'b0);
    we <= 1'b1;
    alt <= 5'h1F;
    @(posedge clk_i) we <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk("restored", {alt_o, jen}, 6'h3F);
    dr(32, 35'h0);
    chk("kept", so[31:0], `IDCODE_VAL);
  endtask

  task automatic t_swd;
    i_probe.preamble();
    repeat (8) @(posedge clk_i);
    chk("swd", {swd, jen}, 2'b10);
  endtask

  // Reset, then the scenarios; wire debug last since it is sticky
  initial begin
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    t_reset();
    t_ident();
    t_bypass();
    t_boundary();
    t_debug();
    t_tap_reset();
    t_pins();
    t_swd();
    tally_and_finish();
  end
endmodule
